// >>> ddr2_ext_mode.sv
// Mode register decode, driver calibration and termination control
`timescale 1ns/1ps
`include "ddr2_ext_mode_regs.svh"
// Operation
// [R1] Set command with bank 010 loads refresh register from A0..A13.
// [R2] Controller precharges all banks, holds clock enable, waits tMRD.
// [R3] Controller writes refresh and spare registers during initialization.
// [R4] Controller drives refresh register bits low except A7.
// [R5] Controller sets A7 for fast self refresh above 85 C.
// [R6] Bank 011 loads spare register, which steers nothing.
// [R7] Controller writes zeros to spare register.
// [R8] Each calibration command is followed by calibration exit.
// [R9] A9..A7 select exit, drive high, drive low, adjust or default.
// [R10] Drive high sets data and strobe high, complement low; reverse.
// [R11] Controller sends 000 on A9..A7 outside calibration.
// [R12] Controller sets burst four and sends one code per adjust.
// [R13] Code bits raise or lower pull-up and pull-down strengths.
// [R14] One pull-up and one pull-down setting shared by all outputs.
// [R15] Sixteen steps; steps beyond either end are ignored.
// [R16] Adjust command keeps earlier additive latency; the code stores A5..A3 from every command, adjust included.
// [R17] Code burst arrives additive plus CAS latency minus one.
// [R18] Code bits are taken in fixed order DT0 to DT3.
// [R19] Outputs start tOIT after drive entry, stop tOIT after exit.
// [R20] Termination pin switches data, strobe, mask; complement if A10 low.
// [R21] Termination in active states, forced off in self refresh.
// [R22] New termination value takes effect within the tMOD window.
// [R23] A6 and A2 select nominal termination resistance.
// [R24] Controller holds termination pin low through tMOD window.
// [R25] Reserved adjustment code leaves both strengths unchanged.
module ddr2_ext_mode #(
  parameter int DQ_W = 16
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Memory link pins
  input  wire logic              mem_clk,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [2:0]        ba,
  input  wire logic [13:0]       addr,
  input  wire logic [DQ_W-1:0]   dq_in,
  input  wire logic              odt,
  input  wire logic              self_refresh,
  output logic      [DQ_W-1:0]   dq_out,
  output logic      [DQ_W-1:0]   dq_oe,
  output logic      [1:0]        dqs_out,
  output logic      [1:0]        dqs_n_out,
  output logic                   dqs_oe,
  // Termination state
  output logic                   term_dq_en,
  output logic                   term_dqs_n_en,
  output logic      [1:0]        term_rtt,
  // Driver strength
  output logic      [3:0]        pullup_step,
  output logic      [3:0]        pulldown_step,
  // AXI4-Lite slave
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  // Three-stage sampling of the link pins; a change counts once
  // stages two and three agree
  localparam int PW = 6 + 3 + 14 + 2;
  wire  [PW-1:0] pin_raw = {mem_clk, cke, cs_n, ras_n, cas_n, we_n, ba,
                            addr, odt, self_refresh};
  logic [PW-1:0] pin_s1, pin_s2, pin_s3, pin_st;
  logic [DQ_W-1:0] dq_s1, dq_s2, dq_s3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      dq_s1  <= '0;
      dq_s2  <= '0;
      dq_s3  <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      dq_s1  <= dq_in;
      dq_s2  <= dq_s1;
      dq_s3  <= dq_s2;
    end
  end

  // Per-bit filter: each bit takes a new value only when stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_st <= '0;
    end else begin
      pin_st <= (pin_s2 & pin_s3) | (pin_st & (pin_s2 ^ pin_s3));
    end
  end

  wire        mclk_st  = pin_st[PW-1];
  wire        cke_st   = pin_st[PW-2];
  wire        cs_n_st  = pin_st[PW-3];
  wire        ras_n_st = pin_st[PW-4];
  wire        cas_n_st = pin_st[PW-5];
  wire        we_n_st  = pin_st[PW-6];
  wire [2:0]  ba_st    = pin_st[PW-7 -: 3];
  wire [13:0] addr_st  = pin_st[PW-10 -: 14];
  wire        odt_st   = pin_st[1];
  wire        sr_st    = pin_st[0];

  logic mclk_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mclk_prev <= 1'b0;
    end else begin
      mclk_prev <= mclk_st;
    end
  end
  wire link_tick = mclk_st && !mclk_prev;

  // Command decode at each link clock rising edge
  wire is_mrs = link_tick && cke_st && !cs_n_st && !ras_n_st &&
                !cas_n_st && !we_n_st;
  wire wr_main    = is_mrs && (ba_st == `BA_MAIN);
  wire wr_drvterm = is_mrs && (ba_st == `BA_DRV_TERM);
  wire wr_refresh = is_mrs && (ba_st == `BA_REFRESH); // [R1]
  wire wr_spare   = is_mrs && (ba_st == `BA_SPARE);   // [R6]
  wire is_write   = link_tick && cke_st && !cs_n_st && ras_n_st &&
                    !cas_n_st && !we_n_st;

  logic [13:0] main_reg, drvterm_reg, refresh_reg, spare_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_reg    <= '0;
      drvterm_reg <= '0;
      refresh_reg <= '0;
      spare_reg   <= '0;
    end else begin
      if (wr_main) main_reg <= addr_st;
      // Additive latency field is stored whatever the calibration code
      if (wr_drvterm) drvterm_reg <= addr_st; // [R16]
      if (wr_refresh) refresh_reg <= addr_st; // [R1]
      if (wr_spare) spare_reg <= addr_st; // [R6]
    end
  end

  // Calibration mode control
  wire [2:0] cal_code = addr_st[`DT_CAL_MSB:`DT_CAL_LSB];
  ddr2_ext_mode_pkg::cal_mode_t cal_mode;
  logic drive_level;
  logic [7:0] oit_cnt;
  logic drv_on;
  logic [7:0] toit_cyc;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_mode    <= ddr2_ext_mode_pkg::cal_idle;
      drive_level <= 1'b0;
    end else if (wr_drvterm) begin
      unique case (cal_code) // [R9]
        `CAL_DRIVE_HIGH: begin
          cal_mode    <= ddr2_ext_mode_pkg::cal_drive;
          drive_level <= 1'b1;
        end
        `CAL_DRIVE_LOW: begin
          cal_mode    <= ddr2_ext_mode_pkg::cal_drive;
          drive_level <= 1'b0;
        end
        `CAL_ADJUST: cal_mode <= ddr2_ext_mode_pkg::cal_adjust;
        default:     cal_mode <= ddr2_ext_mode_pkg::cal_idle;
      endcase
    end
  end

  // Output drivers follow drive mode after tOIT link clocks
  wire drive_req = (cal_mode == ddr2_ext_mode_pkg::cal_drive);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oit_cnt <= '0;
      drv_on  <= 1'b0;
    end else if (drive_req == drv_on) begin
      oit_cnt <= '0;
    end else if (link_tick) begin
      if (oit_cnt >= toit_cyc) begin
        drv_on  <= drive_req; // [R19]
        oit_cnt <= '0;
      end else begin
        oit_cnt <= oit_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_out    <= '0;
      dq_oe     <= '0;
      dqs_out   <= '0;
      dqs_n_out <= '0;
      dqs_oe    <= 1'b0;
    end else begin
      dq_out    <= {DQ_W{drive_level}}; // [R10]
      dqs_out   <= {2{drive_level}};
      dqs_n_out <= {2{!drive_level}};
      dq_oe     <= {DQ_W{drv_on}};
      dqs_oe    <= drv_on;
    end
  end

  // Adjust code capture: wait write latency, then four bit-times
  wire [2:0] al = drvterm_reg[`DT_AL_MSB:`DT_AL_LSB];
  wire [2:0] cl = main_reg[`MR_CL_MSB:`MR_CL_LSB];
  wire [7:0] wl = 8'({5'h0, al}) + 8'({5'h0, cl}) - 8'h01; // [R17]
  ddr2_ext_mode_pkg::cap_state_t cap_state;
  logic [7:0] cap_cnt;
  logic [3:0] code;
  logic [1:0] bit_idx;
  wire  dq0 = dq_s3[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_state <= ddr2_ext_mode_pkg::cap_idle;
      cap_cnt   <= '0;
      code      <= '0;
      bit_idx   <= '0;
    end else begin
      unique case (cap_state)
        ddr2_ext_mode_pkg::cap_idle: begin
          if (is_write && cal_mode == ddr2_ext_mode_pkg::cal_adjust) begin
            cap_state <= ddr2_ext_mode_pkg::cap_wait;
            cap_cnt   <= 8'h01;
          end
        end
        ddr2_ext_mode_pkg::cap_wait: begin
          if (link_tick) begin
            if (cap_cnt >= wl) begin
              // DT0 sits on the very edge that ends the write latency
              cap_state <= ddr2_ext_mode_pkg::cap_bits;
              code[0]   <= dq0; // [R18]
              bit_idx   <= 2'h1;
            end else begin
              cap_cnt <= cap_cnt + 8'h01;
            end
          end
        end
        ddr2_ext_mode_pkg::cap_bits: begin
          // Both edges carry data; sampled on each link clock change
          if (mclk_st != mclk_prev) begin
            code[bit_idx] <= dq0; // [R18]
            bit_idx       <= bit_idx + 2'h1;
            if (bit_idx == 2'h3) begin
              cap_state <= ddr2_ext_mode_pkg::cap_apply;
            end
          end
        end
        ddr2_ext_mode_pkg::cap_apply: begin
          cap_state <= ddr2_ext_mode_pkg::cap_idle;
        end
        default: cap_state <= ddr2_ext_mode_pkg::cap_idle;
      endcase
    end
  end

  // code[0]=DT0 .. code[3]=DT3
  wire pu_up  = code[3] && !code[2];
  wire pu_dn  = code[2] && !code[3];
  wire pd_up  = code[1] && !code[0];
  wire pd_dn  = code[0] && !code[1];
  wire [1:0] pu_cnt = 2'(code[3]) + 2'(code[2]);
  wire [1:0] pd_cnt = 2'(code[1]) + 2'(code[0]);
  wire code_ok = (pu_cnt <= 2'h1) && (pd_cnt <= 2'h1); // [R13] [R25]
  wire apply   = (cap_state == ddr2_ext_mode_pkg::cap_apply) && code_ok;
  wire load_def = wr_drvterm && (cal_code == `CAL_DEFAULT);

  // One shared setting for every data and strobe output
  step_counter u_pullup ( // [R14] [R15]
    .aclk         (aclk),
    .aresetn      (aresetn),
    .load_default (load_def),
    .up           (apply && pu_up),
    .down         (apply && pu_dn),
    .step         (pullup_step)
  );

  step_counter u_pulldown ( // [R14] [R15]
    .aclk         (aclk),
    .aresetn      (aresetn),
    .load_default (load_def),
    .up           (apply && pd_up),
    .down         (apply && pd_dn),
    .step         (pulldown_step)
  );

  // Termination resistance updates after a tMOD delay
  logic [7:0] tmod_cyc;
  logic [7:0] mod_cnt;
  logic       mod_pend;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term_rtt <= '0;
      mod_cnt  <= '0;
      mod_pend <= 1'b0;
    end else if (wr_drvterm) begin
      mod_pend <= 1'b1;
      mod_cnt  <= '0;
    end else if (mod_pend && link_tick) begin
      if (mod_cnt >= tmod_cyc) begin
        term_rtt <= {drvterm_reg[`DT_RTT_HI_BIT],
                     drvterm_reg[`DT_RTT_LO_BIT]}; // [R22] [R23]
        mod_pend <= 1'b0;
      end else begin
        mod_cnt <= mod_cnt + 8'h01;
      end
    end
  end

  wire term_on = odt_st && cke_st && !sr_st; // [R21]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term_dq_en    <= 1'b0;
      term_dqs_n_en <= 1'b0;
    end else begin
      term_dq_en    <= term_on; // [R20]
      term_dqs_n_en <= term_on && !drvterm_reg[`DT_NDQS_DIS_BIT]; // [R20]
    end
  end

  // AXI4-Lite slave: write address and data taken in either order
  logic        aw_got, w_got;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  wire  wr_go = aw_got && w_got;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      toit_cyc     <= `TOIT_CYC;
      tmod_cyc     <= `TMOD_MAX_CYC;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `ADDR_TIMING) ? 2'h0 : 2'h2;
        if (aw_addr == `ADDR_TIMING) begin
          if (w_strb[0]) toit_cyc <= w_data[7:0];
          if (w_strb[1]) tmod_cyc <= w_data[15:8];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [31:0] status_word = {20'h0, drv_on, mod_pend, 2'(cal_mode),
                             pulldown_step, pullup_step};
  wire [31:0] rd_mux =
    (s_axi_araddr == `ADDR_MAIN)     ? {18'h0, main_reg}    :
    (s_axi_araddr == `ADDR_DRV_TERM) ? {18'h0, drvterm_reg} :
    (s_axi_araddr == `ADDR_REFRESH)  ? {18'h0, refresh_reg} :
    (s_axi_araddr == `ADDR_SPARE)    ? {18'h0, spare_reg}   :
    (s_axi_araddr == `ADDR_STATUS)   ? status_word          :
    (s_axi_araddr == `ADDR_TIMING)   ? {16'h0, tmod_cyc, toit_cyc} :
                                       32'h0;
  wire rd_hit = (s_axi_araddr <= `ADDR_STATUS) ||
                (s_axi_araddr == `ADDR_TIMING);
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= (rd_hit && s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : ddr2_ext_mode

// >>> ddr2_ext_mode_regs.svh
// Constants for the extended mode register, calibration and termination block
`ifndef DDR2_EXT_MODE_REGS_SVH
`define DDR2_EXT_MODE_REGS_SVH

// Bank address selection for mode register set commands
`define BA_MAIN          3'h0
`define BA_DRV_TERM      3'h1
`define BA_REFRESH       3'h2
`define BA_SPARE         3'h3

// Field positions in the driver/termination mode register
`define DT_RTT_LO_BIT    2
`define DT_RTT_HI_BIT    6
`define DT_CAL_LSB       7
`define DT_CAL_MSB       9
`define DT_NDQS_DIS_BIT  10
`define DT_AL_LSB        3
`define DT_AL_MSB        5

// Field positions in the main mode register
`define MR_BL_LSB        0
`define MR_BL_MSB        2
`define MR_BL4_CODE      3'h2
`define MR_CL_LSB        4
`define MR_CL_MSB        6

// Refresh mode register: extended self refresh rate bit
`define RF_FAST_BIT      7

// Calibration operation codes on A9..A7
`define CAL_EXIT         3'h0
`define CAL_DRIVE_HIGH   3'h1
`define CAL_DRIVE_LOW    3'h2
`define CAL_ADJUST       3'h4
`define CAL_DEFAULT      3'h7

// Driver strength range and default step
`define STEP_MAX         4'hF
`define STEP_DEFAULT     4'h8

// AXI4-Lite register byte addresses
`define ADDR_MAIN        12'h000
`define ADDR_DRV_TERM    12'h004
`define ADDR_REFRESH     12'h008
`define ADDR_SPARE       12'h00C
`define ADDR_STATUS      12'h010
`define ADDR_CONTROL     12'h014
`define ADDR_TIMING      12'h018

// Timing defaults in link clock cycles
`define TOIT_CYC         8'h02
`define TMOD_MIN_CYC     8'h00
`define TMOD_MAX_CYC     8'h0C

`endif

// >>> ddr2_ext_mode_pkg.sv
// Types shared by the extended mode register block
package ddr2_ext_mode_pkg;
  typedef enum logic [1:0] {
    cal_idle,
    cal_drive,
    cal_adjust
  } cal_mode_t;

  typedef enum logic [2:0] {
    cap_idle,
    cap_wait,
    cap_bits,
    cap_apply
  } cap_state_t;
endpackage : ddr2_ext_mode_pkg

// >>> step_counter.sv
// Saturating driver strength step counter
`timescale 1ns/1ps
`include "ddr2_ext_mode_regs.svh"
module step_counter (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       load_default,
  input  wire logic       up,
  input  wire logic       down,
  // State
  output logic [3:0]      step
);
  wire at_top    = (step == `STEP_MAX);
  wire at_bottom = (step == 4'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step <= `STEP_DEFAULT;
    end else if (load_default) begin
      step <= `STEP_DEFAULT;
    end else if (up && !down && !at_top) begin
      step <= step + 4'h1;
    end else if (down && !up && !at_bottom) begin
      step <= step - 4'h1;
    end
  end
endmodule : step_counter

// >>> ddr2_ext_mode_properties.sv
// Concurrent checks on the drive, termination and strength outputs
`timescale 1ns/1ps
module ddr2_ext_mode_properties #(
  parameter int DQ_W = 16
) (
  // Clock and reset
  input wire logic            aclk,
  input wire logic            aresetn,
  // Termination pins
  input wire logic            odt,
  input wire logic            self_refresh,
  // Drive outputs
  input wire logic [DQ_W-1:0] dq_out,
  input wire logic [DQ_W-1:0] dq_oe,
  input wire logic [1:0]      dqs_out,
  input wire logic [1:0]      dqs_n_out,
  input wire logic            dqs_oe,
  // Termination and strength
  input wire logic            term_dq_en,
  input wire logic            term_dqs_n_en,
  input wire logic [3:0]      pullup_step,
  input wire logic [3:0]      pulldown_step
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  drive_levels_a: assert property (
    dq_oe[0] |-> dq_out == {DQ_W{dqs_out[0]}} && dqs_n_out == ~dqs_out
      && dqs_out[1] == dqs_out[0])
    else $error("drive levels disagree");
  drive_common_a: assert property (dq_oe == {DQ_W{dqs_oe}})
    else $error("drive enables disagree");
  drive_hold_a: assert property ($rose(dqs_oe) |=> dqs_oe [*8])
    else $error("drive dropped early");
  term_on_a: assert property (
    (odt && !self_refresh) [*6] |-> term_dq_en)
    else $error("termination not on");
  term_sr_off_a: assert property (
    self_refresh [*6] |-> !term_dq_en && !term_dqs_n_en)
    else $error("termination on in self refresh");
  term_strobe_a: assert property (term_dqs_n_en |-> term_dq_en)
    else $error("complement termination alone");
  // Five bits so that a wrap from 15 to 0 cannot pass as one step
  pullup_step_a: assert property ($changed(pullup_step) |->
    {1'b0, pullup_step} == {1'b0, $past(pullup_step)} + 5'h01
      || {1'b0, pullup_step} + 5'h01 == {1'b0, $past(pullup_step)}
      || pullup_step == 4'h8)
    else $error("pull-up moved more than one step");
  pulldown_step_a: assert property ($changed(pulldown_step) |->
    {1'b0, pulldown_step} == {1'b0, $past(pulldown_step)} + 5'h01
      || {1'b0, pulldown_step} + 5'h01 == {1'b0, $past(pulldown_step)}
      || pulldown_step == 4'h8)
    else $error("pull-down moved more than one step");
endmodule : ddr2_ext_mode_properties

// >>> ddr2_ctrl_model.sv
// Behavioural memory controller driving the link command and data pins
`timescale 1ns/1ps
module ddr2_ctrl_model #(
  parameter int DQ_W = 16,
  parameter int TMRD = 2
) (
  // Link clock and command
  output logic            mem_clk,
  output logic            cke,
  output logic            cs_n,
  output logic            ras_n,
  output logic            cas_n,
  output logic            we_n,
  output logic [2:0]      ba,
  output logic [13:0]     addr,
  // Data
  output logic [DQ_W-1:0] dq_in
);
  // Memory clock runs free; offset keeps it off the bus clock edges
  initial begin
    mem_clk = 1'b0;
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 3'h0;
    addr = 14'h0000;
    dq_in = '0;
    #7;
    forever #160 mem_clk = ~mem_clk;
  end

  // Released address lines flip so stale values are never seen
  task automatic issue(input logic [2:0] rcw, input logic [2:0] b,
                       input logic [13:0] a);
    @(negedge mem_clk);
    {cs_n, ras_n, cas_n, we_n} <= {1'b0, rcw};
    ba <= b;
    addr <= a;
    @(negedge mem_clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'hF;
    ba <= ~b;
    addr <= ~a;
  endtask : issue

  task automatic mrs(input logic [2:0] b, input logic [13:0] a);
    issue(3'h0, b, a);
    repeat (TMRD - 1) @(negedge mem_clk);
  endtask : mrs

  // Each bit opens one bus cycle before its link edge and spans half a period
  task automatic send_code(input logic [3:0] code, input int wl);
    int i;
    issue(3'h4, 3'h0, 14'h0000);
    #(wl * 320 - 200);
    for (i = 0; i < 4; i++) begin
      dq_in <= {DQ_W{code[i]}};
      #160;
    end
    dq_in <= ~dq_in;
  endtask : send_code
endmodule : ddr2_ctrl_model

// >>> tb_ddr2_ext_mode.sv
// Self-checking bench for mode registers, calibration and termination
`timescale 1ns/1ps
module tb_ddr2_ext_mode;
  localparam int DQ_W = 16;
  logic aclk, aresetn, odt, self_refresh;
  wire logic mem_clk, cke, cs_n, ras_n, cas_n, we_n;
  wire logic [2:0] ba;
  wire logic [13:0] addr;
  wire logic [DQ_W-1:0] dq_in;
  logic [DQ_W-1:0] dq_out, dq_oe;
  logic [1:0] dqs_out, dqs_n_out, term_rtt, s_axi_bresp, s_axi_rresp, rs;
  logic dqs_oe, term_dq_en, term_dqs_n_en;
  logic [3:0] pullup_step, pulldown_step, s_axi_wstrb, code, pu, pd;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int failures, checks, n, i;

  ddr2_ctrl_model #(.DQ_W(DQ_W)) i_ctrl (.*);
  ddr2_ext_mode #(.DQ_W(DQ_W)) i_dut (.*);

  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic timeout;
    failures++;
    $display("[ERR] handshake expected answer seen none");
    tally_and_finish();
  endtask : timeout

  // Ready and valid are sampled mid-cycle, where they equal their edge value
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tk = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tk) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 40) timeout();
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    logic ta, tk;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tk = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tk) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 40) timeout();
  endtask : axi_rd

  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] d, input logic [1:0] r);
    axi_rd(a);
    chk(nm, rd, d);
    chk("rresp", {30'h0, rs}, {30'h0, r});
  endtask : rd_chk

  task automatic ticks(input int k);
    repeat (k) @(posedge mem_clk);
    @(posedge aclk);
  endtask : ticks

  task automatic adjust(input logic [3:0] c);
    i_ctrl.mrs(3'h1, 14'h0200);
    i_ctrl.send_code(c, 2);
    i_ctrl.mrs(3'h1, 14'h0000);
    ticks(3);
  endtask : adjust

  initial begin
    {aresetn, odt, self_refresh, s_axi_awvalid, s_axi_wvalid} = 5'h00;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    failures = 0;
    checks = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("steps", {pulldown_step, pullup_step}, 32'h88);
    rd_chk("timing", 12'h018, 32'h0000_0C02, 2'h0);
    axi_wr(12'h018, 32'h0000_0402);
    chk("bresp", {30'h0, rs}, 32'h0);
    rd_chk("timing", 12'h018, 32'h0000_0402, 2'h0);
    axi_wr(12'h014, 32'hFFFF_FFFF);
    chk("bresp", {30'h0, rs}, 32'h2);
    rd_chk("unmapped", 12'h014, 32'h0, 2'h2);
    i_ctrl.mrs(3'h0, 14'h0032);
    i_ctrl.mrs(3'h2, 14'h0080);
    i_ctrl.mrs(3'h3, 14'h0000);
    i_ctrl.cke <= 1'b0;
    i_ctrl.mrs(3'h2, 14'h0000);
    i_ctrl.cke <= 1'b1;
    axi_wr(12'h000, 32'h0000_00FF);
    chk("bresp", {30'h0, rs}, 32'h2);
    rd_chk("main", 12'h000, 32'h32, 2'h0);
    rd_chk("refresh", 12'h008, 32'h80, 2'h0);
    rd_chk("spare", 12'h00C, 32'h0, 2'h0);
    for (i = 0; i < 2; i++) begin
      i_ctrl.mrs(3'h1, i == 0 ? 14'h0080 : 14'h0100);
      ticks(5);
      chk("dq_oe", dq_oe, {DQ_W{1'b1}});
      chk("dq_out", dq_out, {DQ_W{i == 0}});
      chk("dqs", {dqs_oe, dqs_out, dqs_n_out}, i == 0 ? 5'h1C : 5'h13);
      i_ctrl.mrs(3'h1, 14'h0000);
      ticks(5);
      chk("drive off", {dqs_oe, dq_oe}, 32'h0);
    end
    pu = 4'h8;
    pd = 4'h8;
    // Every code once, then a run that pins both strengths at their ends
    for (i = 0; i < 25; i++) begin
      code = i < 16 ? i[3:0] : 4'h9;
      adjust(code);
      if (!(code[3] && code[2]) && !(code[1] && code[0])) begin
        if (code[3] && pu != 4'hF) pu++;
        if (code[2] && pu != 4'h0) pu--;
        if (code[1] && pd != 4'hF) pd++;
        if (code[0] && pd != 4'h0) pd--;
      end
      axi_rd(12'h010);
      chk("status steps", rd[7:0], {pd, pu});
      chk("step ports", {pulldown_step, pullup_step}, {pd, pu});
    end
    i_ctrl.mrs(3'h1, 14'h0380);
    i_ctrl.mrs(3'h1, 14'h0000);
    ticks(2);
    chk("default steps", {pulldown_step, pullup_step}, 32'h88);
    i_ctrl.mrs(3'h1, 14'h0444);
    ticks(6);
    chk("rtt", term_rtt, 32'h3);
    odt <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("term", {term_dq_en, term_dqs_n_en}, 32'h2);
    odt <= 1'b0;
    i_ctrl.mrs(3'h1, 14'h0040);
    @(posedge aclk);
    chk("rtt early", term_rtt, 32'h3);
    ticks(6);
    chk("rtt", term_rtt, 32'h2);
    odt <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("term", {term_dq_en, term_dqs_n_en}, 32'h3);
    self_refresh <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("term sr", {term_dq_en, term_dqs_n_en}, 32'h0);
    tally_and_finish();
  end
endmodule : tb_ddr2_ext_mode

bind ddr2_ext_mode ddr2_ext_mode_properties #(.DQ_W(DQ_W)) i_props (.*);
